// file: shared/scm_pkg.sv
package scm_pkg;

    // ==========================================================
    // Register map (word aligned, 32-bit APB data)
    // ==========================================================
    localparam logic [7:0] MODE_CTRL_OFS  = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h04;

    // ==========================================================
    // Mode control register fields
    // ==========================================================
    localparam int HCLK_SEL_BIT   = 0;
    localparam int IDLE_SEL_BIT   = 1;
    localparam int HIGH_RDY_BIT   = 2;
    localparam int LOW_RDY_BIT    = 3;
    localparam int FAST_WAKE_BIT  = 4;
    localparam int DIV_SEL_LSB    = 5;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h03;

    // ==========================================================
    // Status register fields
    // ==========================================================
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_CPU_BIT   = 3;
    localparam int STAT_LOW_BIT   = 4;

    // ==========================================================
    // Divider select codes and stabilisation counts
    // ==========================================================
    localparam logic [2:0]  DIV_FIRST_HIGH = 3'h2;
    localparam logic [3:0]  DIV_SHIFT_BASE = 4'h8;
    localparam logic [10:0] XTAL_STAB_CYC  = 11'h400;
    localparam logic [10:0] RC_STAB_CYC    = 11'h010;
    localparam logic [10:0] INTERNAL_SLOW_OSC_STAB_CYC  = 11'h002;
    localparam int          STAB_CNT_W     = 11;

    // ==========================================================
    // Oscillator kinds and system clock sources
    // ==========================================================
    typedef enum logic [1:0] {
        HOSC_FAST_XTAL,
        HOSC_EXT_RC,
        HOSC_EXT_CLK,
        HOSC_INT_FAST
    } scm_hosc_t;

    typedef enum logic {
        LOSC_SLOW_XTAL,
        LOSC_INT_SLOW
    } scm_losc_t;

    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_HIGH,
        SRC_LOW,
        SRC_SUB
    } scm_src_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE0,
        ST_IDLE1,
        ST_SLEEP0,
        ST_SLEEP1,
        ST_WAKE,
        ST_FAST
    } scm_state_t;

endpackage

// file: rtl/scm_stab_timer.sv
module scm_stab_timer #(
    parameter int CNT_W = 11
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             osc_on,
    input  wire logic             osc_tick,
    input  wire logic [CNT_W-1:0] target,
    output logic                  ready
);
    import scm_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             rdy;
    } scm_tmr_t;

    scm_tmr_t r_q;
    scm_tmr_t r_d;

    // ==========================================================
    // Stabilisation count
    // ==========================================================
    // Flag drops whenever the oscillator stops, so a restart always recounts
    always_comb begin
        r_d = r_q;
        if (!osc_on) begin
            r_d.cnt = '0;
            r_d.rdy = 1'b0;
        end else if (!r_q.rdy && osc_tick) begin
            r_d.cnt = r_q.cnt + 1'b1;
            if (r_d.cnt >= target) begin
                r_d.rdy = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign ready = r_q.rdy;

endmodule

// file: rtl/scm_ctrl.sv
// What this block does
// R1: High ready flag clears at power-on, sets once fast oscillator is stable.
// R2: High ready low in sleep or idle0; after wake 1024 or 16 cycles.
// R3: Halt with idle select set enters idle1 or idle0 by sysclk keep bit.
// R4: Halt with idle select clear enters a sleep state.
// R5: High clock select 1 gives undivided high clock, else divide field decides.
// R6: Moving system clock from high to low clock stops the fast oscillator.
// R7: Fast wake runs on substitute clock, only from sleep1 or idle0.
// R8: Crystal fast wake: wake on substitute tick, switch after 1024 crystal cycles.
// R9: RC or external clock wake takes 16 cycles; slow RC 2; fast bit ignored.
// R10: Watchdog off leaves slow oscillators off in sleep0, no fast wake.
// R11: Software clears high select and writes 000 or 001 to go slow.
// R12: Switch to slow clock waits for the low ready flag.
// R13: Software selects high clock again and polls high ready flag.
// R14: Low clock with fast oscillator stopped also stops divide-by-16/64 taps.
// R15: Halt, idle select 0, watchdog and detector off enters sleep0.
// R16: Entering sleep0 clears the watchdog and holds it stopped.
// R17: Any sleep entry sets power-down flag and clears timeout flag.
// R18: Halt, idle select 0, watchdog or detector on enters sleep1.
// R19: Entering sleep1 clears watchdog, keeps it counting on substitute clock.
// R20: Divide field 000/001 low clock; 010..111 high clock over 64 to 2.
// R21: Low ready rises after 1024 slow crystal or 2 slow RC cycles.
// R22: A one-cycle halt request picks the target state on that same clock.
//
// Implementation choices: the APB register port and the placing of the registers.
module scm_ctrl (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire scm_pkg::scm_hosc_t   high_osc_type,
    input  wire scm_pkg::scm_losc_t   low_osc_type,
    input  wire logic                 watchdog_enable,
    input  wire logic                 wdt_clk_from_sub,
    input  wire logic                 low_voltage_detector,
    input  wire logic                 idle_sysclk_keep,
    input  wire logic                 halt_req,
    input  wire logic                 wake_req,
    input  wire logic                 high_osc_tick,
    input  wire logic                 low_osc_tick,
    output logic                      cpu_run,
    output scm_pkg::scm_src_t         sys_clk_src,
    output logic      [2:0]           sys_clk_shift,
    output logic                      high_osc_en,
    output logic                      low_osc_en,
    output logic                      high_div_taps_en,
    output logic                      wdt_clear,
    output logic                      wdt_run,
    output logic                      tbc_run,
    output logic                      power_down_flag_set,
    output logic                      watchdog_timeout_flag_clear,
    output scm_pkg::scm_state_t       power_mode
);
    import scm_pkg::*;

    typedef struct packed {
        scm_state_t  st;
        logic [2:0]  clock_divide_select;
        logic        fast_wake_enable;
        logic        idle_select;
        logic        high_clock_select;
        logic        src_low;
        logic        fast_pend;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        cpu_run;
        scm_src_t    src;
        logic [2:0]  shift;
        logic        hosc_en;
        logic        losc_en;
        logic        taps_en;
        logic        wdt_clear;
        logic        wdt_run;
        logic        tbc_run;
        logic        pd_set;
        logic        to_clr;
    } scm_ctrl_t;

    scm_ctrl_t r_q;
    scm_ctrl_t r_d;

    logic                  high_osc_ready;
    logic                  low_osc_ready;
    logic [STAB_CNT_W-1:0] high_target;
    logic [STAB_CNT_W-1:0] low_target;

    // ==========================================================
    // Oscillator stabilisation
    // ==========================================================
    // Crystal needs the long count; RC and external sources the short one
    assign high_target = (high_osc_type == HOSC_FAST_XTAL) ? XTAL_STAB_CYC  // R2 R9
                                                           : RC_STAB_CYC;
    assign low_target  = (low_osc_type == LOSC_SLOW_XTAL) ? XTAL_STAB_CYC   // R21
                                                          : INTERNAL_SLOW_OSC_STAB_CYC;

    scm_stab_timer #(
        .CNT_W (STAB_CNT_W)
    ) u_high_tmr (
        .pclk     (pclk),
        .presetn  (presetn),
        .osc_on   (r_q.hosc_en),
        .osc_tick (high_osc_tick),
        .target   (high_target),
        .ready    (high_osc_ready)
    );

    scm_stab_timer #(
        .CNT_W (STAB_CNT_W)
    ) u_low_tmr (
        .pclk     (pclk),
        .presetn  (presetn),
        .osc_on   (r_q.losc_en),
        .osc_tick (low_osc_tick),
        .target   (low_target),
        .ready    (low_osc_ready)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic        high_req;
        logic        setup;
        logic        mode_hit;
        logic        stat_hit;
        logic [7:0]  mode_rd;
        logic [7:0]  stat_rd;
        logic        hosc_state;
        high_req   = 1'b0;
        setup      = 1'b0;
        mode_hit   = 1'b0;
        stat_hit   = 1'b0;
        mode_rd    = '0;
        stat_rd    = '0;
        hosc_state = 1'b0;

        r_d             = r_q;
        r_d.wdt_clear   = 1'b0;
        r_d.pd_set      = 1'b0;
        r_d.to_clr      = 1'b0;

        // APB slave: data is prepared in setup, so access ends with no wait
        setup    = psel && !penable;
        mode_hit = (paddr == MODE_CTRL_OFS);
        stat_hit = (paddr == STATUS_OFS);
        mode_rd  = {r_q.clock_divide_select, r_q.fast_wake_enable, low_osc_ready,
                    high_osc_ready, r_q.idle_select, r_q.high_clock_select};
        stat_rd  = {3'h0, r_q.src_low, r_q.cpu_run, r_q.st};
        r_d.pready = setup;
        if (setup) begin
            r_d.pslverr = !(mode_hit || stat_hit);
            r_d.prdata  = '0;
            if (!pwrite && mode_hit) begin
                r_d.prdata[7:0] = mode_rd;
            end else if (!pwrite && stat_hit) begin
                r_d.prdata[7:0] = stat_rd;
            end
        end else begin
            // Error and data stand only for the cycle in which pready is high
            r_d.pslverr = 1'b0;
            r_d.prdata  = '0;
        end
        // Ready flags are read-only: their write lanes are dropped
        if (psel && penable && r_q.pready && pwrite && mode_hit) begin
            r_d.high_clock_select   = pwdata[HCLK_SEL_BIT];
            r_d.idle_select         = pwdata[IDLE_SEL_BIT];
            r_d.fast_wake_enable    = pwdata[FAST_WAKE_BIT];
            r_d.clock_divide_select = pwdata[DIV_SEL_LSB +: 3];
        end

        high_req = r_q.high_clock_select || (r_q.clock_divide_select >= DIV_FIRST_HIGH); // R20

        case (r_q.st)
            ST_RUN: begin
                // Low clock is taken only once it is stable
                if (!high_req && low_osc_ready) begin
                    r_d.src_low = 1'b1; // R12
                end else if (high_req && high_osc_ready) begin
                    r_d.src_low = 1'b0;
                end
                if (halt_req) begin
                    r_d.wdt_clear = 1'b1; // R16 R19
                    r_d.pd_set    = 1'b1; // R17
                    r_d.to_clr    = 1'b1; // R17
                    if (r_q.idle_select) begin
                        r_d.st = idle_sysclk_keep ? ST_IDLE1 : ST_IDLE0; // R3 R22
                    end else if (watchdog_enable || low_voltage_detector) begin
                        r_d.st = ST_SLEEP1; // R4 R18 R22
                    end else begin
                        r_d.st = ST_SLEEP0; // R4 R15 R22
                    end
                end
            end
            ST_IDLE1: begin
                if (wake_req) begin
                    r_d.st = ST_RUN;
                end
            end
            ST_IDLE0, ST_SLEEP1: begin
                if (wake_req) begin
                    r_d.fast_pend = r_q.fast_wake_enable && !r_q.src_low // R7 R9
                                    && (high_osc_type == HOSC_FAST_XTAL);
                    r_d.st        = ST_WAKE;
                end
            end
            ST_SLEEP0: begin
                // Substitute clock is stopped here, so fast wake cannot help
                if (wake_req) begin
                    r_d.fast_pend = 1'b0; // R7 R10
                    r_d.st        = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (r_q.fast_pend) begin
                    if (low_osc_tick) begin
                        r_d.st = ST_FAST; // R8
                    end
                end else if (r_q.src_low ? low_osc_ready : high_osc_ready) begin
                    r_d.st = ST_RUN; // R1 R2 R9
                end
            end
            ST_FAST: begin
                if (high_osc_ready) begin
                    r_d.fast_pend = 1'b0; // R8
                    r_d.st        = ST_RUN;
                end
            end
            default: begin
                r_d.st = ST_WAKE;
            end
        endcase

        // Outputs follow the next state so they settle with it
        r_d.cpu_run = (r_d.st == ST_RUN) || (r_d.st == ST_FAST);
        hosc_state  = (r_d.st == ST_RUN) || (r_d.st == ST_WAKE) ||
                      (r_d.st == ST_FAST) || (r_d.st == ST_IDLE1);
        r_d.hosc_en = hosc_state && (high_req || !r_d.src_low); // R2 R6
        r_d.taps_en = r_d.hosc_en; // R14
        r_d.losc_en = (r_d.st != ST_SLEEP0); // R10 R15

        case (r_d.st)
            ST_RUN, ST_IDLE1: r_d.src = r_d.src_low ? SRC_LOW : SRC_HIGH;
            ST_FAST:          r_d.src = SRC_SUB; // R7 R8
            default:          r_d.src = SRC_OFF; // R15 R18
        endcase
        if (r_q.high_clock_select || r_q.clock_divide_select < DIV_FIRST_HIGH) begin
            r_d.shift = 3'h0; // R5
        end else begin
            r_d.shift = 3'(DIV_SHIFT_BASE - {1'b0, r_q.clock_divide_select}); // R20
        end

        case (r_d.st)
            ST_SLEEP0: r_d.wdt_run = 1'b0; // R16
            ST_SLEEP1: r_d.wdt_run = watchdog_enable && wdt_clk_from_sub; // R19
            ST_IDLE0:  r_d.wdt_run = watchdog_enable && wdt_clk_from_sub;
            ST_WAKE:   r_d.wdt_run = watchdog_enable && wdt_clk_from_sub;
            default:   r_d.wdt_run = watchdog_enable;
        endcase
        r_d.tbc_run = (r_d.st != ST_SLEEP0) && (r_d.st != ST_SLEEP1) && // R15 R18
                      (r_d.st != ST_WAKE);
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Power-on starts in the wake wait so the CPU holds until the clock is stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q                     <= '0;
            r_q.st                  <= ST_WAKE; // R1
            r_q.high_clock_select   <= MODE_CTRL_RESET[HCLK_SEL_BIT];
            r_q.idle_select         <= MODE_CTRL_RESET[IDLE_SEL_BIT];
            r_q.fast_wake_enable    <= MODE_CTRL_RESET[FAST_WAKE_BIT];
            r_q.clock_divide_select <= MODE_CTRL_RESET[DIV_SEL_LSB +: 3];
            r_q.src                 <= SRC_OFF;
            r_q.hosc_en             <= 1'b1;
            r_q.losc_en             <= 1'b1;
            r_q.taps_en             <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata                      = r_q.prdata;
    assign pready                      = r_q.pready;
    assign pslverr                     = r_q.pslverr;
    assign cpu_run                     = r_q.cpu_run;
    assign sys_clk_src                 = r_q.src;
    assign sys_clk_shift               = r_q.shift;
    assign high_osc_en                 = r_q.hosc_en;
    assign low_osc_en                  = r_q.losc_en;
    assign high_div_taps_en            = r_q.taps_en;
    assign wdt_clear                   = r_q.wdt_clear;
    assign wdt_run                     = r_q.wdt_run;
    assign tbc_run                     = r_q.tbc_run;
    assign power_down_flag_set         = r_q.pd_set;
    assign watchdog_timeout_flag_clear = r_q.to_clr;
    assign power_mode                  = r_q.st;

endmodule

// file: tb/scm_ctrl_props.sv
module scm_ctrl_chk
    import scm_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                idle_sysclk_keep,
    input wire logic                watchdog_enable,
    input wire logic                low_voltage_detector,
    input wire logic                halt_req,
    input wire logic                cpu_run,
    input wire scm_pkg::scm_src_t   sys_clk_src,
    input wire logic                high_osc_en,
    input wire logic                high_div_taps_en,
    input wire logic                wdt_clear,
    input wire logic                wdt_run,
    input wire logic                tbc_run,
    input wire logic                power_down_flag_set,
    input wire logic                watchdog_timeout_flag_clear,
    input wire scm_pkg::scm_state_t power_mode
);
    // ======
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_halt; halt_req && power_mode == ST_RUN; endsequence
    sequence s_to_low; sys_clk_src == SRC_HIGH ##1 sys_clk_src == SRC_LOW; endsequence
    property p_pulses; s_halt |=> power_down_flag_set && watchdog_timeout_flag_clear && wdt_clear;
    endproperty
    a_pulses: assert property (p_pulses) else $error("halt entry pulses missing");
    property p_stop;
        s_halt |=> !cpu_run && power_mode inside {ST_IDLE0, ST_IDLE1, ST_SLEEP0, ST_SLEEP1};
    endproperty
    a_stop: assert property (p_stop) else $error("halt did not stop cpu");
    property p_keep; s_halt ##0 !idle_sysclk_keep |=> power_mode != ST_IDLE1; endproperty
    a_keep: assert property (p_keep) else $error("idle1 without keep bit");
    property p_s1; s_halt ##0 (watchdog_enable || low_voltage_detector) |=> power_mode != ST_SLEEP0;
    endproperty
    a_s1: assert property (p_s1) else $error("sleep0 with watchdog or detector on");
    property p_s0; power_mode == ST_SLEEP0 |-> !wdt_run && !tbc_run && sys_clk_src == SRC_OFF;
    endproperty
    a_s0: assert property (p_s0) else $error("clocks running in sleep0");
    property p_taps; !high_osc_en |-> !high_div_taps_en; endproperty
    a_taps: assert property (p_taps) else $error("divider taps run without oscillator");
    // Short grace: the oscillator may drop a cycle or two after the source moves
    property p_hoff; s_to_low |-> ##[0:2] !high_osc_en; endproperty
    a_hoff: assert property (p_hoff) else $error("fast oscillator left on in slow mode");
    property p_fast; power_mode == ST_FAST |-> sys_clk_src == SRC_SUB && cpu_run; endproperty
    a_fast: assert property (p_fast) else $error("fast wake not on substitute clock");
    // A substitute tick comes every 8 cycles, so a wrong fast wake shows within this span
    sequence s_s0_wake; power_mode == ST_SLEEP0 ##1 power_mode == ST_WAKE; endsequence
    property p_nofast; s_s0_wake |=> (power_mode != ST_FAST) [*8]; endproperty
    a_nofast: assert property (p_nofast) else $error("fast wake from sleep0");
    property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb) else $error("bus answer not one cycle after setup");
endmodule

bind scm_ctrl scm_ctrl_chk u_chk (.*);

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import scm_pkg::*;
    // ======
    // Signals
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, rdy, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [2:0]  tcnt = 3'h0, sys_clk_shift;
    logic high_osc_tick, low_osc_tick, watchdog_enable, wdt_clk_from_sub, low_voltage_detector;
    logic idle_sysclk_keep, halt_req, wake_req, cpu_run, high_osc_en, low_osc_en;
    logic high_div_taps_en, wdt_clear, wdt_run, tbc_run;
    logic power_down_flag_set, watchdog_timeout_flag_clear;
    scm_hosc_t  high_osc_type;
    scm_losc_t  low_osc_type;
    scm_src_t   sys_clk_src;
    scm_state_t power_mode;
    int err_total = 0, n_compared = 0, cyc = 0;

    scm_ctrl uut (.*);

    initial forever #10 pclk = ~pclk;
    // Oscillator ticks: fast every 2 cycles, slow every 8
    always @(posedge pclk) begin
        tcnt <= tcnt + 3'h1;
        high_osc_tick <= tcnt[0];
        low_osc_tick <= (tcnt == 3'h7);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    // ======
    // Tasks
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Answer is taken at the rising edge where pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            rdy = pready;
            rdata = prdata;
            rerr = pslverr;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'(rdy), 32'h1);
    endtask

    task automatic kick(input logic h);
        @(posedge pclk);
        halt_req <= h;
        wake_req <= !h;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic halt_to(input scm_state_t st);
        kick(1'b1);
        chk("pd_set", 32'(power_down_flag_set), 32'h1);
        chk("to_clr", 32'(watchdog_timeout_flag_clear), 32'h1);
        chk("wdt_clear", 32'(wdt_clear), 32'h1);
        chk("state", 32'(power_mode), 32'(st));
        chk("cpu_run", 32'(cpu_run), 32'h0);
    endtask

    task automatic wait_mode(input scm_state_t st);
        int n;
        n = 0;
        while (power_mode !== st && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk("state", 32'(power_mode), 32'(st));
    endtask

    task automatic wait_clk(input scm_src_t s, input logic [2:0] sh);
        int n;
        n = 0;
        while ((sys_clk_src !== s || sys_clk_shift !== sh) && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk("src", 32'(sys_clk_src), 32'(s));
        chk("shift", 32'(sys_clk_shift), 32'(sh));
    endtask
    // ======
    // Tests
    initial begin
        {presetn, psel, penable, pwrite, halt_req, wake_req} = '0;
        {low_voltage_detector, idle_sysclk_keep} = '0;
        {watchdog_enable, wdt_clk_from_sub} = 2'h3;
        paddr = 8'h00;
        pwdata = 32'h0;
        high_osc_type = HOSC_FAST_XTAL;
        low_osc_type = LOSC_INT_SLOW;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_mode(ST_RUN);
        apb(1'b0, MODE_CTRL_OFS, 32'h0);
        chk("mode", rdata, 32'h0F);
        apb(1'b0, 8'h08, 32'h0);
        chk("slverr", 32'(rerr), 32'h1);
        apb(1'b1, STATUS_OFS, 32'hFF);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", rdata, 32'h08);
        $display("test reset done");
        idle_sysclk_keep <= 1'b1;
        halt_to(ST_IDLE1);
        chk("src", 32'(sys_clk_src), 32'(SRC_HIGH));
        kick(1'b0);
        wait_mode(ST_RUN);
        idle_sysclk_keep <= 1'b0;
        halt_to(ST_IDLE0);
        apb(1'b0, MODE_CTRL_OFS, 32'h0);
        chk("high_rdy", 32'(rdata[2]), 32'h0);
        kick(1'b0);
        wait_mode(ST_RUN);
        $display("test idle done");
        apb(1'b1, MODE_CTRL_OFS, 32'h11);
        {watchdog_enable, low_voltage_detector} <= 2'h0;
        halt_to(ST_SLEEP0);
        chk("wdt_run", 32'(wdt_run), 32'h0);
        chk("tbc_run", 32'(tbc_run), 32'h0);
        chk("low_en", 32'(low_osc_en), 32'h0);
        kick(1'b0);
        wait_mode(ST_RUN);
        watchdog_enable <= 1'b1;
        halt_to(ST_SLEEP1);
        chk("wdt_run", 32'(wdt_run), 32'h1);
        kick(1'b0);
        wait_mode(ST_FAST);
        chk("src", 32'(sys_clk_src), 32'(SRC_SUB));
        wait_mode(ST_RUN);
        chk("src", 32'(sys_clk_src), 32'(SRC_HIGH));
        $display("test sleep done");
        for (int i = 2; i < 8; i++) begin
            apb(1'b1, MODE_CTRL_OFS, 32'(i) << 5);
            wait_clk(SRC_HIGH, 3'(8 - i));
        end
        apb(1'b1, MODE_CTRL_OFS, 32'h0);
        wait_clk(SRC_LOW, 3'h0);
        repeat (3) @(posedge pclk);
        chk("high_en", 32'(high_osc_en), 32'h0);
        chk("taps", 32'(high_div_taps_en), 32'h0);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", rdata, 32'h18);
        apb(1'b1, MODE_CTRL_OFS, 32'h01);
        wait_clk(SRC_HIGH, 3'h0);
        chk("high_en", 32'(high_osc_en), 32'h1);
        $display("test clock done");
        conclude();
    end
endmodule
